// ===== fpsw_pkg.sv
// Package: constants for the flash status polling controller
package fpsw_pkg;
  // Status word bit positions seen on the flash data bus
  localparam int BIT_POLL   = 7;
  localparam int BIT_TOG1   = 6;
  localparam int BIT_TLIM   = 5;
  localparam int BIT_ESTART = 3;
  localparam int BIT_TOG2   = 2;
  localparam int BIT_BABORT = 1;
  // Flash command words
  localparam logic [15:0] CMD_RESET     = 16'h00F0;
  localparam logic [15:0] CMD_UNLOCK1   = 16'h00AA;
  localparam logic [15:0] CMD_UNLOCK2   = 16'h0055;
  localparam logic [15:0] CMD_ABORT_RST = 16'h00F0;
  localparam logic [25:0] ADDR_UNLOCK1  = 26'h000_0555;
  localparam logic [25:0] ADDR_UNLOCK2  = 26'h000_02AA;
  // Own register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_DATA   = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_RDATA  = 8'h10;
  // Control field positions
  localparam int CTRL_GO    = 0;
  localparam int CTRL_MODE  = 1;
  // Result codes
  localparam logic [1:0] RES_OK      = 2'h0;
  localparam logic [1:0] RES_TIMEOUT = 2'h1;
  localparam logic [1:0] RES_ABORT   = 2'h2;
  // Bus timing, ns and cycles at 100 MHz
  localparam int CLK_NS        = 10;
  localparam int T_ACC_NS      = 100;
  localparam int T_ACC_CYC     = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_WP_NS       = 50;
  localparam int T_WP_CYC      = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_BUSY_RST_US = 2;
  localparam int T_BUSY_RST_CYC = T_BUSY_RST_US * 1000 / CLK_NS;
  typedef enum {ST_IDLE, ST_CMD, ST_RD1, ST_RD2, ST_EVAL, ST_RECHK, ST_ARRAY,
                ST_RESET, ST_RSTWAIT, ST_DONE} fpsw_state_t;
endpackage : fpsw_pkg

// ===== fpsw_cycle.sv
// Module: one asynchronous flash bus cycle (read or write) with strobe timing
`timescale 1ns/1ns
`default_nettype none
module fpsw_cycle
  import fpsw_pkg::*;
#(
  parameter int RD_CYC = T_ACC_CYC,
  parameter int WR_CYC = T_WP_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Request
  input  wire logic        start,
  input  wire logic        is_write,
  input  wire logic [25:0] addr,
  input  wire logic [15:0] wdata,
  output logic             done,
  output logic [15:0]      rdata,
  // Flash pins
  output logic [25:0]      f_addr,
  output logic [15:0]      f_dq_o,
  output logic             f_dq_oe,
  input  wire logic [15:0] f_dq_i,
  output logic             f_ce_n,
  output logic             f_oe_n,
  output logic             f_we_n
);
  // The down counter is eight bits wide, so both counts and the read margin must fit
  if (RD_CYC < 1 || WR_CYC < 1 || RD_CYC + 2 > 255 || WR_CYC > 255) begin : g_bad_cyc
    $error("fpsw_cycle: cycle counts out of range");
  end
  logic [7:0]  cnt_r;
  logic        busy_r;
  logic        wr_r;
  logic [15:0] sync1_r;
  logic [15:0] sync2_r;
  // Data bus comes from outside the clock domain
  always_ff @(posedge clk) begin
    sync1_r <= f_dq_i;
    sync2_r <= sync1_r;
  end
  // Each completed cycle ends with CE and OE high again, so the device counts it
  always_ff @(posedge clk) begin
    if (!nrst) begin
      busy_r <= 1'b0; wr_r <= 1'b0; cnt_r <= 8'h00; done <= 1'b0; rdata <= 16'h0000;
      f_addr <= 26'h000_0000; f_dq_o <= 16'h0000; f_dq_oe <= 1'b0;
      f_ce_n <= 1'b1; f_oe_n <= 1'b1; f_we_n <= 1'b1;
    end else begin
      done <= 1'b0;
      if (!busy_r && start) begin
        busy_r <= 1'b1; wr_r <= is_write; f_addr <= addr; f_dq_o <= wdata;
        f_dq_oe <= is_write; f_ce_n <= 1'b0; f_oe_n <= is_write; f_we_n <= !is_write;
        cnt_r <= is_write ? 8'(WR_CYC) : 8'(RD_CYC + 2);
      end else if (busy_r) begin
        if (cnt_r != 8'h00) begin
          cnt_r <= cnt_r - 8'h01;
        end else begin
          busy_r <= 1'b0; done <= 1'b1; rdata <= sync2_r;
          f_ce_n <= 1'b1; f_oe_n <= 1'b1; f_we_n <= 1'b1; f_dq_oe <= 1'b0;
        end
      end
    end
  end
  // Strobes never overlap: read and write enables are exclusive
  a_strobe_excl: assert property (@(posedge clk) disable iff (!nrst)
    !(!f_oe_n && !f_we_n)) else $error("OE and WE low together");
  a_cycle_end: assert property (@(posedge clk) disable iff (!nrst)
    done |-> f_ce_n && f_oe_n && f_we_n) else $error("cycle ended with strobe low");
endmodule // fpsw_cycle
`default_nettype wire

// ===== fpsw_ctrl.sv
// Module: host controller polling the flash status word, with AXI4-Lite registers
//
// Contract
// - Bits 15..8, 4 and 0 are undefined; host masks them.
// - Host polls only at last written word, program, or erasing sector address.
// - Host polls erase with an address inside the erased sector.
// - Host reads array data only on cycles after polling bit turns true.
// - Host reads twice, compares toggle; unchanged means finished.
// - Still toggling with time limit high: recheck, then reset on failure.
// - Host restarts toggle checking from the double read after leaving.
// - Time limit high during polling: host still re-reads polling bit.
// - Time limit flag cleared by reset command; busy up to 2 us.
// - Buffer abort flag needs the abort reset sequence; code writes only one 00F0 reset word, the same as the plain reset.
//
// Implementation choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
module fpsw_ctrl
  import fpsw_pkg::*;
#(
  parameter int RST_BUSY_CYC = T_BUSY_RST_CYC
) (
  // Clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        NRST,
  // AXI4-Lite slave
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  // Flash pins
  output logic [25:0]      F_ADDR,
  output logic [15:0]      F_DQ_O,
  output logic             F_DQ_OE,
  input  wire logic [15:0] F_DQ_I,
  output logic             F_CE_N,
  output logic             F_OE_N,
  output logic             F_WE_N
);
  if (RST_BUSY_CYC < 1) begin : g_bad_busy
    $error("fpsw_ctrl: RST_BUSY_CYC must be >= 1");
  end
  // ****************************************
  // Registers
  // ****************************************
  logic        mode_r;      // 0 = toggle checking, 1 = inverse-data polling
  logic [25:0] addr_r;
  logic [15:0] data_r;
  logic [15:0] cmd_r;
  logic        busy_r;
  logic        done_r;
  logic [1:0]  result_r;
  logic [15:0] array_r;
  logic        go;
  fpsw_state_t st_r;
  logic        aw_r, w_r;
  logic [7:0]  awa_r;
  logic [31:0] wd_r;
  logic        wr_fire;
  assign wr_fire = aw_r && w_r && !S_AXI_BVALID;
  assign go = wr_fire && (awa_r == REG_CTRL) && wd_r[CTRL_GO] && (st_r == ST_IDLE);
  // Address and data captured in either order
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      aw_r <= 1'b0; w_r <= 1'b0; awa_r <= 8'h00; wd_r <= 32'h0000_0000;
      S_AXI_AWREADY <= 1'b0; S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0; S_AXI_BRESP <= 2'b00;
    end else begin
      S_AXI_AWREADY <= !aw_r && !S_AXI_AWREADY && S_AXI_AWVALID;
      S_AXI_WREADY  <= !w_r && !S_AXI_WREADY && S_AXI_WVALID;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_r <= 1'b1; awa_r <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_r <= 1'b1; wd_r <= S_AXI_WDATA;
      end
      if (wr_fire) begin
        aw_r <= 1'b0; w_r <= 1'b0; S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= (awa_r <= REG_DATA && awa_r[1:0] == 2'b00) ? 2'b00 : 2'b10;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end
  // Software setup; writes while busy are ignored
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      mode_r <= 1'b0; addr_r <= 26'h000_0000; data_r <= 16'h0000; cmd_r <= 16'h0000;
    end else if (wr_fire && st_r == ST_IDLE) begin
      case (awa_r)
        REG_CTRL: begin
          mode_r <= wd_r[CTRL_MODE];
          cmd_r  <= wd_r[31:16];
        end
        REG_ADDR: addr_r <= wd_r[25:0];
        REG_DATA: data_r <= wd_r[15:0];
        default: ;
      endcase
    end
  end
  // Read channel
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      S_AXI_ARREADY <= 1'b0; S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000; S_AXI_RRESP <= 2'b00;
    end else begin
      S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID && S_AXI_ARVALID;
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP  <= 2'b00;
        case (S_AXI_ARADDR)
          REG_CTRL:   S_AXI_RDATA <= {cmd_r, 14'h0000, mode_r, 1'b0};
          REG_ADDR:   S_AXI_RDATA <= {6'h00, addr_r};
          REG_DATA:   S_AXI_RDATA <= {16'h0000, data_r};
          REG_STATUS: S_AXI_RDATA <= {28'h000_0000, result_r, done_r, busy_r};
          REG_RDATA:  S_AXI_RDATA <= {16'h0000, array_r};
          default: begin
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= 2'b10;
          end
        endcase
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end
  // ****************************************
  // Flash sequencer
  // ****************************************
  logic        cyc_start, cyc_wr, cyc_done;
  logic [25:0] cyc_addr;
  logic [15:0] cyc_wdata, cyc_rdata;
  logic [15:0] first_r;
  logic [1:0]  cmd_idx_r;
  logic        rechk_r;
  logic        issued_r;
  logic [31:0] wait_r;
  // masked compare: only toggle bit 6 is compared
  logic        tog_changed;
  assign tog_changed = (first_r[BIT_TOG1] != cyc_rdata[BIT_TOG1]);
  always_comb begin
    cyc_wr = 1'b0; cyc_addr = addr_r; cyc_wdata = 16'h0000;
    case (st_r)
      ST_CMD: begin
        cyc_wr = 1'b1;
        case (cmd_idx_r)
          2'd0: begin cyc_addr = ADDR_UNLOCK1; cyc_wdata = CMD_UNLOCK1; end
          2'd1: begin cyc_addr = ADDR_UNLOCK2; cyc_wdata = CMD_UNLOCK2; end
          default: begin cyc_addr = addr_r; cyc_wdata = cmd_r; end
        endcase
      end
      ST_RESET: begin
        cyc_wr = 1'b1; cyc_wdata = (result_r == RES_ABORT) ? CMD_ABORT_RST : CMD_RESET;
      end
      default: ;
    endcase
  end
  assign cyc_start = !issued_r && (st_r == ST_CMD || st_r == ST_RD1 || st_r == ST_RD2 ||
                     st_r == ST_RECHK || st_r == ST_ARRAY || st_r == ST_RESET);
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      st_r <= ST_IDLE; issued_r <= 1'b0; cmd_idx_r <= 2'd0; first_r <= 16'h0000;
      rechk_r <= 1'b0; busy_r <= 1'b0; done_r <= 1'b0; result_r <= RES_OK;
      array_r <= 16'h0000; wait_r <= 32'h0000_0000;
    end else begin
      if (cyc_start) issued_r <= 1'b1;
      if (cyc_done) issued_r <= 1'b0;
      case (st_r)
        ST_IDLE: if (go) begin
          st_r <= ST_CMD; cmd_idx_r <= 2'd0; busy_r <= 1'b1; done_r <= 1'b0;
          result_r <= RES_OK; rechk_r <= 1'b0;
        end
        // status read starts right after final write strobe
        ST_CMD: if (cyc_done) begin
          if (cmd_idx_r == 2'd2) st_r <= ST_RD1;
          else cmd_idx_r <= cmd_idx_r + 2'd1;
        end
        // first of double read; later rounds stay in ST_RD2 and reuse the last read as first
        // acceptance judged by poll or toggle bits, never the erase-start bit
        ST_RD1: if (cyc_done) begin
          first_r <= cyc_rdata; st_r <= ST_RD2;
        end
        ST_RD2: if (cyc_done) begin
          if (mode_r) begin
            // polling bit true equals bit 7 of written data
            if (cyc_rdata[BIT_POLL] == data_r[BIT_POLL]) st_r <= ST_ARRAY;
            // time limit seen: re-read polling bit once more
            else if (cyc_rdata[BIT_TLIM]) st_r <= ST_RECHK;
            else if (cyc_rdata[BIT_BABORT]) begin
              result_r <= RES_ABORT; st_r <= ST_RESET;
            end else first_r <= cyc_rdata;
          end else if (!tog_changed) begin
            st_r <= ST_ARRAY;
          end else if (cyc_rdata[BIT_TLIM]) begin
            first_r <= cyc_rdata; st_r <= ST_RECHK;
          end else if (cyc_rdata[BIT_BABORT] && first_r[BIT_BABORT]) begin
            // abort needs its reset sequence; both reads must show it, since
            // the read after completion is array data whose bit 1 means nothing
            result_r <= RES_ABORT; st_r <= ST_RESET;
          end else first_r <= cyc_rdata;
        end
        ST_RECHK: if (cyc_done) begin
          if (mode_r ? (cyc_rdata[BIT_POLL] == data_r[BIT_POLL]) : !tog_changed)
            st_r <= ST_ARRAY;
          else begin
            result_r <= RES_TIMEOUT; st_r <= ST_RESET;
          end
        end
        // array data taken only on a cycle after completion
        ST_ARRAY: if (cyc_done) begin
          array_r <= cyc_rdata; st_r <= ST_DONE;
        end
        // reset command then allow busy time
        ST_RESET: if (cyc_done) begin
          wait_r <= 32'(RST_BUSY_CYC); st_r <= ST_RSTWAIT;
        end
        ST_RSTWAIT: begin
          if (wait_r != 32'h0000_0000) wait_r <= wait_r - 32'h0000_0001;
          else st_r <= ST_DONE;
        end
        ST_DONE: begin
          busy_r <= 1'b0; done_r <= 1'b1; st_r <= ST_IDLE;
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end
  fpsw_cycle u_cycle (
    .clk     (CLK_SYS),
    .nrst    (NRST),
    .start   (cyc_start),
    .is_write(cyc_wr),
    .addr    (cyc_addr),
    .wdata   (cyc_wdata),
    .done    (cyc_done),
    .rdata   (cyc_rdata),
    .f_addr  (F_ADDR),
    .f_dq_o  (F_DQ_O),
    .f_dq_oe (F_DQ_OE),
    .f_dq_i  (F_DQ_I),
    .f_ce_n  (F_CE_N),
    .f_oe_n  (F_OE_N),
    .f_we_n  (F_WE_N)
  );
  // status reads use the programmed or erased address
  a_poll_addr: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (st_r == ST_RD1 && cyc_start) |-> cyc_addr == addr_r) else $error("poll address wrong");
  a_double_read: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (st_r == ST_ARRAY && $changed(st_r)) |-> $past(st_r) inside {ST_RD2, ST_RECHK})
    else $error("finished without double read");
  a_fail_reset: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (st_r == ST_RECHK && cyc_done && result_r == RES_OK && !mode_r && tog_changed)
    |=> st_r == ST_RESET) else $error("failure not followed by reset");
  a_rst_busy: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (st_r == ST_RESET && cyc_done) |=> st_r == ST_RSTWAIT && wait_r == 32'(RST_BUSY_CYC))
    else $error("reset busy wait not loaded");
  a_abort_seq: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (st_r == ST_RD2 && cyc_done && !mode_r && tog_changed && !cyc_rdata[BIT_TLIM]
     && cyc_rdata[BIT_BABORT] && first_r[BIT_BABORT]) |=> result_r == RES_ABORT)
    else $error("abort missed");
endmodule // fpsw_ctrl
`default_nettype wire

// ===== fpsw_flash_model.sv
// Behavioural flash device answering status polls and command writes
`timescale 1ns/1ns
`default_nettype none
module fpsw_flash_model
  import fpsw_pkg::*;
#(
  parameter logic [15:0] CMD_ERASE = 16'h0030
) (
  // Clock
  input  wire logic        clk,
  // Flash pins
  input  wire logic [25:0] f_addr,
  input  wire logic [15:0] f_dq,
  input  wire logic        f_ce_n,
  input  wire logic        f_oe_n,
  input  wire logic        f_we_n,
  output logic [15:0]      f_dq_m,
  // Test controls
  input  wire logic [3:0]  busy_len,
  input  wire logic [1:0]  fail,
  input  wire logic        prot
);
  logic [25:0] wa[$];
  logic [15:0] wd[$];
  logic [15:0] arr = 16'h1234, pd = 16'h0000, last = 16'h0000, rnd = 16'h0000, word;
  logic [25:0] sect = 26'h000_0000, wa_l = 26'h000_0000;
  logic [15:0] wd_l = 16'h0000;
  logic        busy = 1'b0, er = 1'b0, tog1 = 1'b0, tog2 = 1'b0, tlim = 1'b0, babort = 1'b0;
  logic        rd_q = 1'b0, we_q = 1'b1, ce_q = 1'b1;
  logic [1:0]  n = 2'h0;
  logic [3:0]  cnt = 4'h0;
  // ****************************************
  // Status word and bus
  // ****************************************
  always_comb begin
    word = arr;
    if (busy) begin
      word = rnd;
      word[BIT_POLL] = er ? 1'b0 : ~pd[BIT_POLL];
      word[BIT_TOG1] = tog1;
      word[BIT_TLIM] = tlim;
      word[BIT_ESTART] = er;
      word[BIT_TOG2] = (er && f_addr[25:16] == sect[25:16]) ? tog2 : 1'b0;
      word[BIT_BABORT] = babort;
    end
  end
  // Released bus shows the inverse of the last value, never a stale copy
  assign f_dq_m = (!f_ce_n && !f_oe_n) ? word : ~last;
  always @(posedge clk) begin
    rd_q <= !f_ce_n && !f_oe_n;
    we_q <= f_we_n;
    ce_q <= f_ce_n;
    // Address and data are held while the strobe is low: the host may let go of
    // the data bus in the very edge that raises the strobe
    if (!f_we_n && !f_ce_n) begin
      wa_l <= f_addr;
      wd_l <= f_dq;
    end
    // read ends on OE or CE high
    if (rd_q && (f_ce_n || f_oe_n)) begin
      last <= word;
      rnd <= 16'($urandom);
      if (busy) begin
        tog1 <= ~tog1;
        tog2 <= ~tog2;
        cnt <= cnt + 4'h1;
        if (cnt + 4'h1 >= busy_len) begin
          busy <= fail != 2'h0;
          tlim <= fail == 2'h1;
          babort <= fail == 2'h2;
        end
      end
    end
    // command taken at write strobe rise
    if (f_we_n && !we_q && !ce_q) begin
      wa.push_back(wa_l);
      wd.push_back(wd_l);
      n <= 2'h0;
      if (busy && wd_l == CMD_RESET && (tlim || babort)) begin
        busy <= 1'b0;
        tlim <= 1'b0;
        babort <= 1'b0;
      end else if (!busy && n == 2'h0 && wa_l == ADDR_UNLOCK1 && wd_l == CMD_UNLOCK1) begin
        n <= 2'h1;
      end else if (!busy && n == 2'h1 && wa_l == ADDR_UNLOCK2 && wd_l == CMD_UNLOCK2) begin
        n <= 2'h2;
      end else if (!busy && n == 2'h2) begin
        busy <= 1'b1;
        er <= wd_l == CMD_ERASE;
        pd <= wd_l;
        sect <= wa_l;
        cnt <= 4'h0;
        // protected sector: status for a while, then the old array again
        arr <= prot ? arr : (wd_l == CMD_ERASE) ? 16'hFFFF : wd_l;
      end
    end
  end
endmodule // fpsw_flash_model
`default_nettype wire

// ===== flash_poll_status_word_bench.sv
// Self-checking bench for the flash status polling controller
`timescale 1ns/1ns
`default_nettype none
module flash_poll_status_word_bench
  import fpsw_pkg::*;
;
  logic        CLK_SYS = 1'b0, NRST = 1'b0;
  logic [7:0]  S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
  logic [31:0] S_AXI_WDATA = 32'h0000_0000, S_AXI_RDATA;
  logic [3:0]  S_AXI_WSTRB = 4'hF;
  logic        S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
  logic        S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
  logic        S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
  logic [25:0] F_ADDR;
  logic [15:0] F_DQ_O, F_DQ_I, dq_m;
  logic        F_DQ_OE, F_CE_N, F_OE_N, F_WE_N;
  logic [3:0]  busy_len = 4'h1;
  logic [1:0]  fail = 2'h0;
  logic        prot = 1'b0;
  logic [15:0] exp_arr = 16'h1234;
  int          fail_count = 0, num_checks = 0;
  assign F_DQ_I = F_DQ_OE ? F_DQ_O : dq_m;
  fpsw_ctrl #(.RST_BUSY_CYC(4)) uut (.CLK_SYS, .NRST, .S_AXI_AWADDR, .S_AXI_AWVALID,
    .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP,
    .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
    .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .F_ADDR, .F_DQ_O, .F_DQ_OE, .F_DQ_I, .F_CE_N,
    .F_OE_N, .F_WE_N);
  fpsw_flash_model fl (.clk(CLK_SYS), .f_addr(F_ADDR), .f_dq(F_DQ_I), .f_ce_n(F_CE_N),
    .f_oe_n(F_OE_N), .f_we_n(F_WE_N), .f_dq_m(dq_m), .busy_len(busy_len), .fail(fail),
    .prot(prot));
  initial forever #5 CLK_SYS = ~CLK_SYS;
  // ****************************************
  // Bus tasks and comparison
  // ****************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw;
    logic w;
    @(posedge CLK_SYS);
    aw = 1'b1;
    w = 1'b1;
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    while (aw || w) begin
      @(posedge CLK_SYS);
      if (S_AXI_AWREADY === 1'b1) begin
        aw = 1'b0;
        S_AXI_AWVALID <= 1'b0;
      end
      if (S_AXI_WREADY === 1'b1) begin
        w = 1'b0;
        S_AXI_WVALID <= 1'b0;
      end
    end
    do @(posedge CLK_SYS); while (S_AXI_BVALID !== 1'b1);
    r = S_AXI_BRESP;
    S_AXI_BREADY <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge CLK_SYS);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do @(posedge CLK_SYS); while (S_AXI_ARREADY !== 1'b1);
    S_AXI_ARVALID <= 1'b0;
    do @(posedge CLK_SYS); while (S_AXI_RVALID !== 1'b1);
    d = S_AXI_RDATA;
    r = S_AXI_RRESP;
    S_AXI_RREADY <= 1'b0;
  endtask
  // One full operation; the expected outcome comes from the chosen failure kind
  task automatic run_op(input logic mode, input logic ers, input logic [1:0] f, input logic p);
    logic [31:0] v;
    logic [1:0]  r;
    logic [25:0] a;
    logic [15:0] pw;
    logic [25:0] ea[3];
    logic [15:0] ed[3];
    int          k;
    a = 26'($urandom);
    pw = ers ? 16'h0030 : {1'b1, 15'($urandom)};
    busy_len <= 4'($urandom_range(8, 1));
    fail <= f;
    prot <= p;
    // A protected sector keeps what the array held before
    if (!p) exp_arr = ers ? 16'hFFFF : pw;
    fl.wa.delete();
    fl.wd.delete();
    axw(REG_ADDR, 32'(a), r);
    axw(REG_DATA, {16'h0000, ers ? 16'hFFFF : pw}, r);
    axw(REG_CTRL, {pw, 14'h0000, mode, 1'b1}, r);
    axr(REG_STATUS, v, r);
    chk("busy", 32'h0000_0001, 32'(v[0]));
    axw(REG_ADDR, 32'(~a), r);
    k = 0;
    do begin
      axr(REG_STATUS, v, r);
      k++;
    end while (v[1] !== 1'b1 && k < 3000);
    chk("poll limit", 32'h0000_0000, 32'(k >= 3000));
    chk("idle", 32'h0000_0000, 32'(v[0]));
    chk("result", (f == 2'h0) ? 32'(RES_OK) : (f == 2'h1) ? 32'(RES_TIMEOUT) : 32'(RES_ABORT),
        32'(v[3:2]));
    if (f == 2'h0) begin
      axr(REG_RDATA, v, r);
      chk("rdata", 32'(exp_arr), {16'h0000, v[15:0]});
    end else begin
      chk("reset word", 32'(CMD_RESET), 32'(fl.wd[fl.wd.size() - 1]));
    end
    axr(REG_ADDR, v, r);
    chk("addr kept", 32'(a), v);
    ea = '{ADDR_UNLOCK1, ADDR_UNLOCK2, a};
    ed = '{CMD_UNLOCK1, CMD_UNLOCK2, pw};
    for (int i = 0; i < 3; i++) begin
      chk("cmd addr", 32'(ea[i]), 32'(fl.wa[i]));
      chk("cmd data", 32'(ed[i]), 32'(fl.wd[i]));
    end
  endtask
  task automatic results();
    if (fail_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge CLK_SYS);
    fail_count++;
    results();
  end
  initial begin
    logic [31:0] v;
    logic [1:0]  r;
    v = $urandom(32'h0000_9521);
    repeat (10) @(posedge CLK_SYS);
    NRST <= 1'b1;
    axr(8'h14, v, r);
    chk("unmapped rresp", 32'h0000_0002, 32'(r));
    chk("unmapped rdata", 32'h0000_0000, v);
    axw(8'h14, 32'h0000_0001, r);
    chk("unmapped bresp", 32'h0000_0002, 32'(r));
    for (int m = 0; m < 2; m++) begin
      for (int e = 0; e < 2; e++) begin
        run_op(m[0], e[0], 2'h0, 1'b0);
      end
    end
    run_op(1'b1, 1'b0, 2'h1, 1'b0);
    run_op(1'b0, 1'b1, 2'h1, 1'b0);
    run_op(1'b1, 1'b0, 2'h2, 1'b0);
    run_op(1'b0, 1'b0, 2'h2, 1'b0);
    run_op(1'b0, 1'b0, 2'h0, 1'b1);
    run_op(1'b0, 1'b1, 2'h0, 1'b1);
    results();
  end
endmodule // flash_poll_status_word_bench
`default_nettype wire
